// File: rtl/pmio_cfg.svh
// Register offsets, reset values and product-term counts of the macrocell I/O port block
`ifndef PMIO_CFG_SVH
`define PMIO_CFG_SVH

// Per-port registers: base plus port index (0=A, 1=B, 2=C, 3=D); control exists only for A and B
`define PMIO_OFF_DIN_BASE 8'h00
`define PMIO_OFF_CTRL_BASE 8'h04
`define PMIO_OFF_DOUT_BASE 8'h08
`define PMIO_OFF_DIR_BASE 8'h0C
// Output cell groups, write masks and input cell read buffers
`define PMIO_OFF_OC_A 8'h10
`define PMIO_OFF_OC_B 8'h11
`define PMIO_OFF_MASK_A 8'h12
`define PMIO_OFF_MASK_B 8'h13
`define PMIO_OFF_IC_A 8'h14
`define PMIO_OFF_IC_B 8'h15
`define PMIO_OFF_IC_C 8'h16

`define PMIO_MASK_RST 8'h00
`define PMIO_PORT_RST 8'h00

// Product-term capacity per output cell
`define PMIO_PT_NATIVE_A 3
`define PMIO_PT_BORROW_A 6
`define PMIO_PT_NATIVE_B 4
`define PMIO_PT_BORROW_B_LO 5
`define PMIO_PT_BORROW_B_HI 6

`define PMIO_NUM_PINS 27
`define PMIO_NUM_IC 20

`endif

// File: rtl/pmio_pkg.sv
// Types shared by the macrocell I/O port block
package pmio_pkg;
    typedef enum logic [1:0] {
        PMIO_IC_PASS = 2'b00,
        PMIO_IC_LATCH = 2'b01,
        PMIO_IC_REG = 2'b10
    } pmio_ic_mode_type;
endpackage

// File: rtl/pmio_output_cell.sv
// One output cell: product-term sum, polarity, flip-flop with MCU load override
`timescale 1ns/1ps
module pmio_output_cell
    import pmio_pkg::*;
#(
    parameter int TERMS = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // MCU load
    input wire logic load,
    input wire logic load_data,
    // Logic array side
    input wire logic [TERMS-1:0] terms,
    input wire logic expand,
    input wire logic invert,
    input wire logic comb,
    input wire logic pt_clk,
    input wire logic preset,
    input wire logic clear,
    // Dedicated clock select
    input wire logic use_macrocell_clock_in,
    input wire logic macrocell_clock_in_rise,
    // Cell output
    output logic q_out
);
    logic q_r;
    logic expand_r;
    logic pt_clk_r;
    logic sum;
    logic clk_en;

    // Expansion terms from another cell pass a register stage, so they cost latency
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            expand_r <= 1'b0;
            pt_clk_r <= 1'b0;
        end else begin
            expand_r <= expand;
            pt_clk_r <= pt_clk;
        end
    end

    assign sum = (|terms | expand_r) ^ invert;
    assign clk_en = use_macrocell_clock_in ? macrocell_clock_in_rise : (pt_clk & !pt_clk_r);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_r <= 1'b0;
        end else if (load) begin
            q_r <= load_data;
        end else if (clear) begin
            q_r <= 1'b0;
        end else if (preset) begin
            q_r <= 1'b1;
        end else if (clk_en) begin
            q_r <= sum;
        end
    end

    assign q_out = comb ? sum : q_r;
endmodule

// File: rtl/pmio_input_cell.sv
// Four input cells sharing one latch enable or register clock
`timescale 1ns/1ps
module pmio_input_cell
    import pmio_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Shared gate
    input wire logic gate,
    // Per-cell mode and pins
    input wire logic [2*WIDTH-1:0] mode,
    input wire logic [WIDTH-1:0] pin,
    // Cell outputs
    output logic [WIDTH-1:0] q
);
    logic gate_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= gate;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_cell
        pmio_ic_mode_type m;
        assign m = pmio_ic_mode_type'(mode[2*i+:2]);
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                q[i] <= 1'b0;
            end else begin
                unique case (m)
                    PMIO_IC_LATCH: if (gate) q[i] <= pin[i];
                    PMIO_IC_REG: if (gate && !gate_r) q[i] <= pin[i];
                    default: q[i] <= pin[i];
                endcase
            end
        end
    end
endmodule

// File: rtl/pmio_top.sv
// Macrocell I/O ports: output and input cells, four ports, MCU register access
// How it works
// - The MCU loads each of the 16 output cells, overriding preset, clear and clock.
// - Loads happen on write-strobe release or throughout the strobe, as configured.
// - Each output group has an 8-bit write mask, reset to zero; ones block loads.
// - Pin driver enable is the enable product term ORed with the direction bit.
// - With no enable term and no logic output, the direction bit alone drives enable.
// - A logic output without enable equation drives its pin from power-up.
// - An output cell kept internal frees its pin but still feeds the array.
// - Twenty input cells, each a latch, an edge register or a pass-through.
// - Input gate is address strobe or a product term; one term per four bits.
// - Input cells feed the logic input bus and a dedicated MCU read buffer.
// - Three 8-bit ports and one 3-bit port, each pin set up individually.
// - Pin mux picks data-out, latched address, cell output or chip select.
// - Each MCU read puts at most one source onto the data bus.
// - In MCU I/O mode pins drive data-out and read back through data-in.
// - Ports without control bits stay MCU I/O unless logic is assigned.
// - In logic I/O the pin floats when enable term and direction are both off.
// - Programmed modes are fixed; register modes take effect the cycle after the write.
// - Group a: 3+6 terms; group b cells 0-3: 4+5; cells 4-7: 4+6.
// - Terms are private to a cell; expansion via other cells adds delay.
// - Dedicated clock captures on rising edge; preset and clear active high.
// - Direction 1 means output, 0 input; input after reset.
`timescale 1ns/1ps
`include "pmio_cfg.svh"
module pmio_top
    import pmio_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // MCU register access in the io register space
    input wire logic BUS_SEL,
    input wire logic [7:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    // MCU address strobe and latched address
    input wire logic ALE,
    input wire logic [7:0] LATCH_ADDR,
    // Output cell product terms, group a then b
    input wire logic [71:0] OC_TERMS_A,
    input wire logic [35:0] OC_TERMS_B_LO,
    input wire logic [39:0] OC_TERMS_B_HI,
    input wire logic [15:0] OC_EXPAND,
    input wire logic [15:0] OC_PT_CLK,
    input wire logic [15:0] OC_PRESET,
    input wire logic [15:0] OC_CLEAR,
    input wire logic MACROCELL_CLOCK_IN,
    // Output cell static configuration
    input wire logic [1:0] CFG_OC_LEVEL_LOAD,
    input wire logic [15:0] CFG_OC_INVERT,
    input wire logic [15:0] CFG_OC_COMB,
    input wire logic [15:0] CFG_OC_USE_MACROCELL_CLOCK_IN,
    input wire logic [15:0] CFG_OC_NODE,
    input wire logic [7:0] CFG_PB_FROM_GROUP_B,
    // Input cell configuration and gate terms
    input wire logic [39:0] CFG_IC_MODE,
    input wire logic [4:0] CFG_IC_GATE_PT,
    input wire logic [4:0] IC_GATE_TERM,
    // Pin configuration: A in 7:0, B 15:8, C 23:16, D 26:24
    input wire logic [26:0] CFG_PLD_OUT,
    input wire logic [26:0] OE_PT_DEF,
    input wire logic [26:0] OE_PT,
    input wire logic [1:0] EXTERNAL_CHIP_SELECTS,
    // Pins
    input wire logic [26:0] PIN_IN,
    output logic [26:0] PIN_OUT,
    output logic [26:0] PIN_OE,
    // Logic array feedback
    output logic [15:0] OC_FEEDBACK,
    output logic [19:0] IC_BUS
);
    logic [7:0] dout_r [0:3];
    logic [7:0] dir_r [0:3];
    logic [7:0] ctrl_r [0:1];
    logic [7:0] mask_a_r;
    logic [7:0] mask_b_r;
    logic [7:0] rdata_nxt;
    logic wr_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic macrocell_clock_in_r;
    logic [15:0] oc_val;
    logic [15:0] oc_load;
    logic [7:0] load_data;
    logic [19:0] ic_q;
    logic [26:0] mc_val;
    logic [26:0] mc_node;
    logic wr_now;
    logic wr_end;

    assign wr_now = BUS_SEL && BUS_WR;

    // Remember the access so edge loading can act after the strobe is gone
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            macrocell_clock_in_r <= 1'b0;
        end else begin
            wr_r <= wr_now;
            addr_r <= BUS_ADDR;
            wdata_r <= BUS_WDATA;
            macrocell_clock_in_r <= MACROCELL_CLOCK_IN;
        end
    end

    assign wr_end = wr_r && !wr_now;

    // Port registers take effect the cycle after the write
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int p = 0; p < 4; p++) begin
                dout_r[p] <= `PMIO_PORT_RST;
                dir_r[p] <= `PMIO_PORT_RST;
            end
            ctrl_r[0] <= `PMIO_PORT_RST;
            ctrl_r[1] <= `PMIO_PORT_RST;
        end else if (wr_now) begin
            if (BUS_ADDR[7:2] == `PMIO_OFF_DOUT_BASE >> 2) begin
                dout_r[BUS_ADDR[1:0]] <= BUS_WDATA;
            end
            if (BUS_ADDR[7:2] == `PMIO_OFF_DIR_BASE >> 2) begin
                dir_r[BUS_ADDR[1:0]] <= BUS_WDATA;
            end
            if (BUS_ADDR[7:1] == `PMIO_OFF_CTRL_BASE >> 1) begin
                ctrl_r[BUS_ADDR[0]] <= BUS_WDATA;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mask_a_r <= `PMIO_MASK_RST;
            mask_b_r <= `PMIO_MASK_RST;
        end else if (wr_now) begin
            if (BUS_ADDR == `PMIO_OFF_MASK_A) mask_a_r <= BUS_WDATA;
            if (BUS_ADDR == `PMIO_OFF_MASK_B) mask_b_r <= BUS_WDATA;
        end
    end

    // Level loading follows the live strobe; edge loading uses the held access
    always_comb begin
        load_data = CFG_OC_LEVEL_LOAD[0] ? BUS_WDATA : wdata_r;
        oc_load[7:0] = 8'h00;
        oc_load[15:8] = 8'h00;
        if (CFG_OC_LEVEL_LOAD[0] ? (wr_now && BUS_ADDR == `PMIO_OFF_OC_A)
                                 : (wr_end && addr_r == `PMIO_OFF_OC_A)) begin
            oc_load[7:0] = ~mask_a_r;
        end
        if (CFG_OC_LEVEL_LOAD[1] ? (wr_now && BUS_ADDR == `PMIO_OFF_OC_B)
                                 : (wr_end && addr_r == `PMIO_OFF_OC_B)) begin
            oc_load[15:8] = ~mask_b_r;
        end
    end

    // Group b has its own load mode bit, so it needs its own bus data selector
    logic [7:0] load_data_b;
    assign load_data_b = CFG_OC_LEVEL_LOAD[1] ? BUS_WDATA : wdata_r;

    for (genvar c = 0; c < 16; c++) begin : g_oc
        localparam int TERMS = (c < 8) ? `PMIO_PT_NATIVE_A + `PMIO_PT_BORROW_A
                             : (c < 12) ? `PMIO_PT_NATIVE_B + `PMIO_PT_BORROW_B_LO
                             : `PMIO_PT_NATIVE_B + `PMIO_PT_BORROW_B_HI;
        logic [TERMS-1:0] terms;
        if (c < 8) begin : g_a
            assign terms = OC_TERMS_A[c*TERMS+:TERMS];
        end else if (c < 12) begin : g_blo
            assign terms = OC_TERMS_B_LO[(c-8)*TERMS+:TERMS];
        end else begin : g_bhi
            assign terms = OC_TERMS_B_HI[(c-12)*TERMS+:TERMS];
        end
        pmio_output_cell #(.TERMS(TERMS)) u_cell (
            .clk(CLK),
            .reset_n(RESET_N),
            .load(oc_load[c]),
            .load_data((c < 8) ? load_data[c%8] : load_data_b[c%8]),
            .terms(terms),
            .expand(OC_EXPAND[c]),
            .invert(CFG_OC_INVERT[c]),
            .comb(CFG_OC_COMB[c]),
            .pt_clk(OC_PT_CLK[c]),
            .preset(OC_PRESET[c]),
            .clear(OC_CLEAR[c]),
            .use_macrocell_clock_in(CFG_OC_USE_MACROCELL_CLOCK_IN[c]),
            .macrocell_clock_in_rise(MACROCELL_CLOCK_IN && !macrocell_clock_in_r),
            .q_out(oc_val[c])
        );
    end

    // Internal nodes keep feeding the array even when not routed to a pin
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            OC_FEEDBACK <= 16'h0000;
            IC_BUS <= 20'h00000;
        end else begin
            OC_FEEDBACK <= oc_val;
            IC_BUS <= ic_q;
        end
    end

    // Nibble n covers pins 4n..4n+3 of ports A, B and C[3:0]
    for (genvar n = 0; n < 5; n++) begin : g_ic
        pmio_input_cell #(.WIDTH(4)) u_ic (
            .clk(CLK),
            .reset_n(RESET_N),
            .gate(CFG_IC_GATE_PT[n] ? IC_GATE_TERM[n] : ALE),
            .mode(CFG_IC_MODE[8*n+:8]),
            .pin(PIN_IN[4*n+:4]),
            .q(ic_q[4*n+:4])
        );
    end

    // Macrocell source for each pin
    for (genvar p = 0; p < 27; p++) begin : g_src
        localparam int BIT = p % 8;
        if (p < 8) begin : g_pa
            assign mc_val[p] = oc_val[BIT];
            assign mc_node[p] = CFG_OC_NODE[BIT];
        end else if (p < 16) begin : g_pb
            assign mc_val[p] = CFG_PB_FROM_GROUP_B[BIT] ? oc_val[8+BIT] : oc_val[BIT];
            assign mc_node[p] = CFG_PB_FROM_GROUP_B[BIT] ? CFG_OC_NODE[8+BIT]
                                                         : CFG_OC_NODE[BIT];
        end else if (p < 24 && (BIT == 2 || BIT == 3 || BIT == 4 || BIT == 7)) begin : g_pc
            assign mc_val[p] = oc_val[8+BIT];
            assign mc_node[p] = CFG_OC_NODE[8+BIT];
        end else if (p >= 25) begin : g_pd
            assign mc_val[p] = EXTERNAL_CHIP_SELECTS[p-25];
            assign mc_node[p] = 1'b0;
        end else begin : g_none
            assign mc_val[p] = 1'b0;
            assign mc_node[p] = 1'b1;
        end
    end

    for (genvar p = 0; p < 27; p++) begin : g_pin
        localparam int PORT = p / 8;
        localparam int BIT = p % 8;
        logic logic_out;
        logic addr_mode;
        assign logic_out = CFG_PLD_OUT[p] && !mc_node[p];
        if (PORT < 2) begin : g_ctrl
            assign addr_mode = ctrl_r[PORT][BIT];
        end else begin : g_noctrl
            assign addr_mode = 1'b0;
        end
        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                PIN_OUT[p] <= 1'b0;
                PIN_OE[p] <= 1'b0;
            end else begin
                PIN_OUT[p] <= logic_out ? mc_val[p]
                            : addr_mode ? LATCH_ADDR[BIT]
                            : dout_r[PORT][BIT];
                PIN_OE[p] <= (OE_PT_DEF[p] && OE_PT[p]) || dir_r[PORT][BIT]
                           || (logic_out && !OE_PT_DEF[p]);
            end
        end
    end

    // One source per read; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (BUS_ADDR[7:2] == `PMIO_OFF_DIN_BASE >> 2) begin
            unique case (BUS_ADDR[1:0])
                2'h0: rdata_nxt = PIN_IN[7:0];
                2'h1: rdata_nxt = PIN_IN[15:8];
                2'h2: rdata_nxt = PIN_IN[23:16];
                default: rdata_nxt = {5'h00, PIN_IN[26:24]};
            endcase
        end else if (BUS_ADDR[7:2] == `PMIO_OFF_DOUT_BASE >> 2) begin
            rdata_nxt = dout_r[BUS_ADDR[1:0]] & ((BUS_ADDR[1:0] == 2'h3) ? 8'h07 : 8'hFF);
        end else if (BUS_ADDR[7:2] == `PMIO_OFF_DIR_BASE >> 2) begin
            rdata_nxt = dir_r[BUS_ADDR[1:0]] & ((BUS_ADDR[1:0] == 2'h3) ? 8'h07 : 8'hFF);
        end else if (BUS_ADDR[7:1] == `PMIO_OFF_CTRL_BASE >> 1) begin
            rdata_nxt = ctrl_r[BUS_ADDR[0]];
        end else begin
            unique case (BUS_ADDR)
                `PMIO_OFF_OC_A: rdata_nxt = oc_val[7:0];
                `PMIO_OFF_OC_B: rdata_nxt = oc_val[15:8];
                `PMIO_OFF_MASK_A: rdata_nxt = mask_a_r;
                `PMIO_OFF_MASK_B: rdata_nxt = mask_b_r;
                `PMIO_OFF_IC_A: rdata_nxt = ic_q[7:0];
                `PMIO_OFF_IC_B: rdata_nxt = ic_q[15:8];
                `PMIO_OFF_IC_C: rdata_nxt = {4'h0, ic_q[19:16]};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            BUS_RDATA <= 8'h00;
        end else begin
            BUS_RDATA <= (BUS_SEL && BUS_RD) ? rdata_nxt : 8'h00;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_oc_b_write;
        BUS_SEL && BUS_WR && BUS_ADDR == `PMIO_OFF_OC_B && !CFG_OC_LEVEL_LOAD[1]
            && !mask_b_r[0] && !CFG_OC_COMB[8];
    endsequence
    sequence s_strobe_release;
        !(BUS_SEL && BUS_WR);
    endsequence

    chk_level_load: assert property (
        (BUS_SEL && BUS_WR && BUS_ADDR == `PMIO_OFF_OC_A && CFG_OC_LEVEL_LOAD[0]
         && !mask_a_r[0] && !CFG_OC_COMB[0]) |=> oc_val[0] == $past(BUS_WDATA[0]))
        else $error("level load did not reach output cell");
    chk_edge_load: assert property (
        (s_oc_b_write ##1 s_strobe_release) |=> oc_val[8] == $past(wdata_r[0], 1))
        else $error("edge load did not happen at strobe release");
    // Quiet cell: no clear, preset or clock, so only a load could change it
    chk_mask_blocks: assert property (
        (BUS_SEL && BUS_WR && BUS_ADDR == `PMIO_OFF_OC_A && CFG_OC_LEVEL_LOAD[0]
         && mask_a_r[0] && !CFG_OC_COMB[0] && !OC_CLEAR[0] && !OC_PRESET[0]
         && !CFG_OC_USE_MACROCELL_CLOCK_IN[0] && !OC_PT_CLK[0]) |=> $stable(oc_val[0]))
        else $error("masked output cell was loaded");
    chk_mask_reset: assert property (
        $rose(RESET_N) |-> mask_a_r == 8'h00 && mask_b_r == 8'h00)
        else $error("write mask not zero after reset");
    chk_dir_enables: assert property (
        dir_r[2][2] |=> PIN_OE[18])
        else $error("direction bit did not enable the driver");
    chk_logic_out_oe: assert property (
        (CFG_PLD_OUT[25] && !OE_PT_DEF[25]) |=> PIN_OE[25])
        else $error("logic output without enable term not driven");
    chk_addr_out: assert property (
        (ctrl_r[1][3] && !CFG_PLD_OUT[11]) |=> PIN_OUT[11] == $past(LATCH_ADDR[3]))
        else $error("address out pin does not follow latched address");
    chk_mcu_io_out: assert property (
        (!ctrl_r[1][5] && !CFG_PLD_OUT[13]) |=> PIN_OUT[13] == $past(dout_r[1][5]))
        else $error("mcu io pin does not follow data-out register");
    chk_dir_readback: assert property (
        (BUS_SEL && BUS_RD && BUS_ADDR == `PMIO_OFF_DIR_BASE) |=> BUS_RDATA == $past(dir_r[0]))
        else $error("direction readback mismatch");
    chk_float_off: assert property (
        (!dir_r[2][2] && OE_PT_DEF[18] && !OE_PT[18]) |=> !PIN_OE[18])
        else $error("pin driven with enable term and direction off");
endmodule

// File: testbench/pmio_mcu_model.sv
// Bus-master model of the MCU core reaching the io register space
`timescale 1ns/1ps
module pmio_mcu_model (
    // Clock
    input wire logic clk,
    // Register bus
    output logic bus_sel,
    output logic [7:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    // Idle address and data flip every time, so a stale copy never looks like a request
    task automatic idle();
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask

    initial begin
        bus_addr = 8'hFF;
        bus_wdata = 8'hFF;
        idle();
    end

    // Extra cycles hold the strobe: level loading repeats, edge loading acts once on release
    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input int slow);
        @(negedge clk);
        bus_sel = 1'b1;
        bus_addr = addr;
        bus_wdata = data;
        bus_wr = 1'b1;
        repeat (slow) @(negedge clk);
        @(negedge clk);
        idle();
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        bus_sel = 1'b1;
        bus_addr = addr;
        bus_rd = 1'b1;
        @(negedge clk);
        data = bus_rdata;
        idle();
    endtask
endmodule

// File: testbench/pmio_top_tb.sv
// Self-checking bench for the macrocell I/O port block
`timescale 1ns/1ps
`include "pmio_cfg.svh"
module pmio_top_tb;
    logic clk, reset_n, bus_sel, bus_wr, bus_rd, ale, macrocell_clock_in;
    logic [7:0] bus_addr, bus_wdata, bus_rdata, latch_addr, pb_from_b;
    logic [71:0] terms_a;
    logic [35:0] terms_b_lo;
    logic [39:0] terms_b_hi, ic_mode;
    logic [15:0] oc_exp, oc_ptclk, oc_pre, oc_clr, oc_inv, oc_comb, oc_macrocell_clock_in, oc_node, oc_fb;
    logic [1:0] level_load, ecs;
    logic [4:0] ic_gate_pt, ic_gate_term;
    logic [26:0] pld_out, oe_def, oe_pt, pin_in, pin_out, pin_oe;
    logic [19:0] ic_bus;
    int num_errors, n_compared;

    pmio_mcu_model i_pmio_mcu_model (.clk(clk), .bus_sel(bus_sel), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

    pmio_top i_pmio_top (.CLK(clk), .RESET_N(reset_n), .BUS_SEL(bus_sel), .BUS_ADDR(bus_addr),
        .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
        .ALE(ale), .LATCH_ADDR(latch_addr), .OC_TERMS_A(terms_a), .OC_TERMS_B_LO(terms_b_lo),
        .OC_TERMS_B_HI(terms_b_hi), .OC_EXPAND(oc_exp), .OC_PT_CLK(oc_ptclk),
        .OC_PRESET(oc_pre), .OC_CLEAR(oc_clr), .MACROCELL_CLOCK_IN(macrocell_clock_in),
        .CFG_OC_LEVEL_LOAD(level_load), .CFG_OC_INVERT(oc_inv), .CFG_OC_COMB(oc_comb),
        .CFG_OC_USE_MACROCELL_CLOCK_IN(oc_macrocell_clock_in), .CFG_OC_NODE(oc_node), .CFG_PB_FROM_GROUP_B(pb_from_b),
        .CFG_IC_MODE(ic_mode), .CFG_IC_GATE_PT(ic_gate_pt), .IC_GATE_TERM(ic_gate_term),
        .CFG_PLD_OUT(pld_out), .OE_PT_DEF(oe_def), .OE_PT(oe_pt),
        .EXTERNAL_CHIP_SELECTS(ecs), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .OC_FEEDBACK(oc_fb), .IC_BUS(ic_bus));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        i_pmio_mcu_model.rd(addr, v);
        chk_byte(v, exp);
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic sc_reset();
        settle();
        chk_byte({7'h00, pin_oe[25]}, 8'h01);
        chk_byte(pin_oe[7:0] | pin_oe[15:8], 8'h00);
        rd_chk(`PMIO_OFF_MASK_A, `PMIO_MASK_RST);
        rd_chk(`PMIO_OFF_MASK_B, `PMIO_MASK_RST);
    endtask

    task automatic sc_mcu_io();
        i_pmio_mcu_model.wr(`PMIO_OFF_CTRL_BASE, 8'h00, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_DOUT_BASE, 8'hA5, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_DIR_BASE, 8'h0F, 0);
        pin_in[7:0] = 8'h3C;
        settle();
        chk_byte(pin_oe[7:0], 8'h0F);
        chk_byte(pin_out[7:0] & 8'h0F, 8'h05);
        rd_chk(`PMIO_OFF_DIN_BASE, 8'h3C);
        rd_chk(`PMIO_OFF_DIR_BASE, 8'h0F);
        rd_chk(`PMIO_OFF_DOUT_BASE, 8'hA5);
    endtask

    task automatic sc_addr_out();
        latch_addr = 8'h3C;
        i_pmio_mcu_model.wr(`PMIO_OFF_CTRL_BASE + 8'h01, 8'hFF, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_DIR_BASE + 8'h01, 8'hFF, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_DOUT_BASE + 8'h01, 8'h81, 0);
        settle();
        chk_byte(pin_oe[15:8], 8'hFF);
        chk_byte(pin_out[15:8], 8'h3C);
        i_pmio_mcu_model.wr(`PMIO_OFF_CTRL_BASE + 8'h01, 8'h00, 0);
        settle();
        chk_byte(pin_out[15:8], 8'h81);
    endtask

    task automatic sc_oc_load();
        i_pmio_mcu_model.wr(`PMIO_OFF_OC_A, 8'h3C, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_MASK_A, 8'h0F, 0);
        i_pmio_mcu_model.wr(`PMIO_OFF_OC_A, 8'hFF, 2);
        i_pmio_mcu_model.wr(`PMIO_OFF_OC_B, 8'h5A, 3);
        settle();
        rd_chk(`PMIO_OFF_OC_A, 8'hFC);
        rd_chk(`PMIO_OFF_OC_B, 8'h5A);
        rd_chk(`PMIO_OFF_MASK_A, 8'h0F);
        chk_byte(oc_fb[15:8], 8'h5A);
    endtask

    // Masked cell 0 is still clocked by the dedicated clock and cleared by its term
    task automatic sc_macrocell_clock_in();
        oc_macrocell_clock_in[0] = 1'b1;
        terms_a[0] = 1'b1;
        @(negedge clk);
        macrocell_clock_in = 1'b1;
        @(negedge clk);
        macrocell_clock_in = 1'b0;
        settle();
        rd_chk(`PMIO_OFF_OC_A, 8'hFD);
        oc_clr[0] = 1'b1;
        settle();
        rd_chk(`PMIO_OFF_OC_A, 8'hFC);
    endtask

    task automatic sc_input_cells();
        pin_in[15:8] = 8'hC3;
        ic_mode[7:0] = 8'hAA;
        ic_mode[15:8] = 8'h55;
        pin_in[3:0] = 4'h6;
        @(negedge clk);
        ale = 1'b1;
        @(negedge clk);
        ale = 1'b0;
        pin_in[3:0] = 4'h9;
        pin_in[7:4] = 4'hA;
        settle();
        chk_byte(ic_bus[15:8], 8'hC3);
        rd_chk(`PMIO_OFF_IC_B, 8'hC3);
        rd_chk(`PMIO_OFF_IC_A, 8'h36);
        ic_gate_pt[0] = 1'b1;
        @(negedge clk);
        ic_gate_term[0] = 1'b1;
        @(negedge clk);
        ic_gate_term[0] = 1'b0;
        settle();
        rd_chk(`PMIO_OFF_IC_A, 8'h39);
    endtask

    task automatic sc_logic_oe();
        settle();
        chk_byte({7'h00, pin_oe[18]}, 8'h00);
        oe_pt[18] = 1'b1;
        settle();
        chk_byte({7'h00, pin_oe[18]}, 8'h01);
        oe_pt[18] = 1'b0;
        i_pmio_mcu_model.wr(`PMIO_OFF_DIR_BASE + 8'h02, 8'h04, 0);
        settle();
        chk_byte({7'h00, pin_oe[18]}, 8'h01);
        i_pmio_mcu_model.wr(8'h40, 8'hFF, 0);
        rd_chk(8'h40, 8'h00);
        ecs = 2'b01;
        settle();
        chk_byte({7'h00, pin_out[25]}, 8'h01);
    endtask

    initial begin
        {ale, macrocell_clock_in, latch_addr, pb_from_b, terms_a, terms_b_lo, terms_b_hi} = '0;
        {oc_exp, oc_ptclk, oc_pre, oc_clr, oc_inv, oc_comb, oc_macrocell_clock_in, oc_node} = '0;
        {ecs, ic_mode, ic_gate_pt, ic_gate_term, oe_pt, pin_in} = '0;
        num_errors = 0;
        n_compared = 0;
        level_load = 2'b01;
        pld_out = 27'h2040000;
        oe_def = 27'h0040000;
        reset_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        sc_reset();
        sc_mcu_io();
        sc_addr_out();
        sc_oc_load();
        sc_macrocell_clock_in();
        sc_input_cells();
        sc_logic_oe();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule
